//--- common/itcr_map.svh
// Register offsets, field positions, reset values and timing counts of the I2C timing block
`ifndef ITCR_MAP_SVH
`define ITCR_MAP_SVH

`define ITCR_OFS_TIMING_CTRL     8'h10
`define ITCR_OFS_SCL_HIGH        8'h11
`define ITCR_OFS_SCL_LOW         8'h12
`define ITCR_OFS_GP_BITS         8'h13
`define ITCR_OFS_SELFTEST        8'h14

`define ITCR_HOLD_MSB            6
`define ITCR_HOLD_LSB            4
`define ITCR_DEPTH_MSB           3
`define ITCR_DEPTH_LSB           0
`define ITCR_CLKSRC_MSB          2
`define ITCR_CLKSRC_LSB          1

`define ITCR_RST_HOLD            3'h1
`define ITCR_RST_DEPTH           4'h7
`define ITCR_RST_SCL_HIGH        8'h82
`define ITCR_RST_SCL_LOW         8'h82
`define ITCR_RST_GP_BITS         8'h00
`define ITCR_RST_CLKSRC          2'h0

`define ITCR_CLK_PERIOD_NS       10
`define ITCR_RING_UNIT_NS        50
`define ITCR_FILTER_UNIT_NS      10
`define ITCR_RING_CYCLES         ((`ITCR_RING_UNIT_NS + `ITCR_CLK_PERIOD_NS - 1) / `ITCR_CLK_PERIOD_NS)
`define ITCR_FILTER_CYCLES       ((`ITCR_FILTER_UNIT_NS + `ITCR_CLK_PERIOD_NS - 1) / `ITCR_CLK_PERIOD_NS)

`endif

//--- common/itcr_pkg.sv
// Types shared by the I2C timing configuration block
package itcr_pkg;

	typedef struct packed {
		logic       rsvd7;
		logic [2:0] sda_hold;
		logic [3:0] filter_depth;
	} itcr_ctrl_t;

	typedef struct packed {
		logic [1:0] rsvd43;
		logic [1:0] clock_source;
		logic       rsvd0;
	} itcr_selftest_t;

	typedef enum logic [1:0] {
		ITCR_MST_IDLE,
		ITCR_MST_HIGH,
		ITCR_MST_LOW
	} itcr_mst_state_t;

	typedef enum logic [1:0] {
		ITCR_SLV_IDLE,
		ITCR_SLV_HOLD,
		ITCR_SLV_SETUP
	} itcr_slv_state_t;

endpackage : itcr_pkg

//--- hw/itcr_glitch_filter.sv
// Pin synchroniser and programmable glitch filter for one I2C line
`timescale 1ns/1ps
`include "itcr_map.svh"

module itcr_glitch_filter #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       pin_i,
	input  wire logic [3:0] depth_i,
	output logic            level_o
);

	logic [2:0] sync_reg;
	logic [2:0] sync_next;
	logic       level_reg;
	logic       level_next;
	logic [7:0] run_reg;
	logic [7:0] run_next;
	logic [7:0] limit;

	// Depth in 10 ns units, converted to clock cycles
	assign limit = 8'(depth_i) * 8'(`ITCR_FILTER_CYCLES);

	// Only the agreement of stages two and three counts; stage one feeds stage two alone
	always_comb begin
		sync_next  = {sync_reg[1:0], pin_i};
		level_next = level_reg;
		run_next   = 8'h00;
		if ((sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg)) begin
			// Pulse must outlast the depth to be accepted
			if (run_reg >= limit) begin
				level_next = sync_reg[2];
			end else begin
				run_next = run_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sync_reg  <= {3{RESET_LEVEL}};
			level_reg <= RESET_LEVEL;
			run_reg   <= 8'h00;
		end else begin
			sync_reg  <= sync_next;
			level_reg <= level_next;
			run_reg   <= run_next;
		end
	end

	assign level_o = level_reg;

endmodule : itcr_glitch_filter

//--- hw/itcr_timing.sv
// I2C timing configuration registers with SCL generator, slave setup stretch and SDA hold
// How it works
// - Received SDA is held for the programmed count of 50 ns after SCL falls.
// - Pulses on SCL and SDA no wider than depth times 10 ns are rejected.
// - As master, each SCL high phase lasts the high count of 50 ns units in which SCL is seen high.
// - As master, each SCL low phase lasts the low count of 50 ns units.
// - As slave, data stands for the low count before stretched SCL is released.
// - The 50 ns unit is one ring clock period; reset counts suit 26 MHz.
// - A 2-bit clock source field for the forward frame only drives clock_source_o; the ring clock stays at 50 ns.
`timescale 1ns/1ps
`include "itcr_map.svh"

module itcr_timing (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            scl_o,
	output logic            scl_oe_o,
	input  wire logic       mst_run_i,
	input  wire logic       slv_stretch_i,
	input  wire logic       slv_data_ready_i,
	output logic            slv_release_o,
	output logic            scl_rx_o,
	output logic            sda_rx_o,
	output logic            mst_busy_o,
	output logic      [1:0] clock_source_o,
	output logic      [7:0] general_purpose_bits_field_o
);

	localparam logic [2:0] RING_LAST = 3'(`ITCR_RING_CYCLES - 1);

	// Register file
	itcr_pkg::itcr_ctrl_t     ctrl_reg,     ctrl_next;
	itcr_pkg::itcr_selftest_t selftest_reg, selftest_next;
	logic [7:0]               scl_high_reg, scl_high_next;
	logic [7:0]               scl_low_reg,  scl_low_next;
	logic [7:0]               gp_reg,       gp_next;
	logic [7:0]               rdata_reg,    rdata_next;

	// Register writes and registered read data; unmapped reads return zero
	always_comb begin
		ctrl_next     = ctrl_reg;
		selftest_next = selftest_reg;
		scl_high_next = scl_high_reg;
		scl_low_next  = scl_low_reg;
		gp_next       = gp_reg;
		rdata_next    = rdata_reg;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`ITCR_OFS_TIMING_CTRL: ctrl_next = reg_wdata_i;
				`ITCR_OFS_SCL_HIGH:    scl_high_next = reg_wdata_i;
				`ITCR_OFS_SCL_LOW:     scl_low_next = reg_wdata_i;
				`ITCR_OFS_GP_BITS:     gp_next = reg_wdata_i;
				`ITCR_OFS_SELFTEST:    selftest_next = reg_wdata_i[4:0];
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ITCR_OFS_TIMING_CTRL: rdata_next = ctrl_reg;
				`ITCR_OFS_SCL_HIGH:    rdata_next = scl_high_reg;
				`ITCR_OFS_SCL_LOW:     rdata_next = scl_low_reg;
				`ITCR_OFS_GP_BITS:     rdata_next = gp_reg;
				`ITCR_OFS_SELFTEST:    rdata_next = {3'h0, selftest_reg}; // Top bits read only
				default:               rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl_reg     <= {1'b0, `ITCR_RST_HOLD, `ITCR_RST_DEPTH};
			scl_high_reg <= `ITCR_RST_SCL_HIGH;
			scl_low_reg  <= `ITCR_RST_SCL_LOW;
			gp_reg       <= `ITCR_RST_GP_BITS;
			selftest_reg <= {2'h0, `ITCR_RST_CLKSRC, 1'b0};
			rdata_reg    <= 8'h00;
		end else begin
			ctrl_reg     <= ctrl_next;
			scl_high_reg <= scl_high_next;
			scl_low_reg  <= scl_low_next;
			gp_reg       <= gp_next;
			selftest_reg <= selftest_next;
			rdata_reg    <= rdata_next;
		end
	end

	assign reg_rdata_o                  = rdata_reg;
	assign clock_source_o               = selftest_reg.clock_source;
	assign general_purpose_bits_field_o = gp_reg;

	// Filtered views of the bus lines
	logic scl_f;
	logic sda_f;

	itcr_glitch_filter #(.RESET_LEVEL(1'b1)) u_scl_filter (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.pin_i   (scl_i),
		.depth_i (ctrl_reg.filter_depth),
		.level_o (scl_f)
	);

	itcr_glitch_filter #(.RESET_LEVEL(1'b1)) u_sda_filter (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.pin_i   (sda_i),
		.depth_i (ctrl_reg.filter_depth),
		.level_o (sda_f)
	);

	// Ring clock tick, one per 50 ns; stands in for the internal oscillator period
	logic [2:0] ring_reg, ring_next;
	logic       ring_tick;

	assign ring_tick = (ring_reg == RING_LAST);

	always_comb begin
		ring_next = ring_tick ? 3'h0 : ring_reg + 3'h1;
	end

	// SDA hold after SCL falls, in ring ticks
	logic       scl_prev_reg, scl_prev_next;
	logic [2:0] hold_reg,     hold_next;
	logic       sda_rx_reg,   sda_rx_next;
	logic       scl_fall;

	assign scl_fall = scl_prev_reg & ~scl_f;

	always_comb begin
		scl_prev_next = scl_f;
		hold_next     = hold_reg;
		sda_rx_next   = sda_rx_reg;
		if (scl_fall) begin
			hold_next = ctrl_reg.sda_hold;
		end else if (hold_reg != 3'h0) begin
			if (ring_tick) begin
				hold_next = hold_reg - 3'h1;
			end
		end else begin
			sda_rx_next = sda_f;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ring_reg     <= 3'h0;
			scl_prev_reg <= 1'b1;
			hold_reg     <= 3'h0;
			sda_rx_reg   <= 1'b1;
		end else begin
			ring_reg     <= ring_next;
			scl_prev_reg <= scl_prev_next;
			hold_reg     <= hold_next;
			sda_rx_reg   <= sda_rx_next;
		end
	end

	assign sda_rx_o = sda_rx_reg;
	assign scl_rx_o = scl_f;

	// Master SCL generator; a high phase only counts while the line is seen high,
	// so a slave that stretches the clock lengthens the phase instead of being overrun
	itcr_pkg::itcr_mst_state_t mst_reg, mst_next;
	logic [7:0]                mcnt_reg, mcnt_next;

	always_comb begin
		mst_next  = mst_reg;
		mcnt_next = mcnt_reg;
		unique case (mst_reg)
			itcr_pkg::ITCR_MST_IDLE: begin
				if (mst_run_i) begin
					mst_next  = itcr_pkg::ITCR_MST_LOW;
					mcnt_next = scl_low_reg;
				end
			end
			itcr_pkg::ITCR_MST_LOW: begin
				if (ring_tick) begin
					if (mcnt_reg <= 8'h01) begin
						mst_next  = mst_run_i ? itcr_pkg::ITCR_MST_HIGH : itcr_pkg::ITCR_MST_IDLE;
						mcnt_next = scl_high_reg;
					end else begin
						mcnt_next = mcnt_reg - 8'h01;
					end
				end
			end
			itcr_pkg::ITCR_MST_HIGH: begin
				if (ring_tick && scl_f) begin
					if (mcnt_reg <= 8'h01) begin
						mst_next  = itcr_pkg::ITCR_MST_LOW;
						mcnt_next = scl_low_reg;
					end else begin
						mcnt_next = mcnt_reg - 8'h01;
					end
				end
			end
			default: mst_next = itcr_pkg::ITCR_MST_IDLE;
		endcase
	end

	// Slave stretch: hold SCL low, then give data a full low count before release
	itcr_pkg::itcr_slv_state_t slv_reg, slv_next;
	logic [7:0]                scnt_reg, scnt_next;
	logic                      rel_reg, rel_next;

	always_comb begin
		slv_next  = slv_reg;
		scnt_next = scnt_reg;
		rel_next  = 1'b0;
		unique case (slv_reg)
			itcr_pkg::ITCR_SLV_IDLE: begin
				if (slv_stretch_i) begin
					slv_next = itcr_pkg::ITCR_SLV_HOLD;
				end
			end
			itcr_pkg::ITCR_SLV_HOLD: begin
				if (slv_data_ready_i) begin
					slv_next  = itcr_pkg::ITCR_SLV_SETUP;
					scnt_next = scl_low_reg;
				end
			end
			itcr_pkg::ITCR_SLV_SETUP: begin
				if (ring_tick) begin
					if (scnt_reg <= 8'h01) begin
						slv_next = itcr_pkg::ITCR_SLV_IDLE;
						rel_next = 1'b1;
					end else begin
						scnt_next = scnt_reg - 8'h01;
					end
				end
			end
			default: slv_next = itcr_pkg::ITCR_SLV_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mst_reg  <= itcr_pkg::ITCR_MST_IDLE;
			mcnt_reg <= 8'h00;
			slv_reg  <= itcr_pkg::ITCR_SLV_IDLE;
			scnt_reg <= 8'h00;
			rel_reg  <= 1'b0;
		end else begin
			mst_reg  <= mst_next;
			mcnt_reg <= mcnt_next;
			slv_reg  <= slv_next;
			scnt_reg <= scnt_next;
			rel_reg  <= rel_next;
		end
	end

	// Open-drain SCL: enable pulls low during master low phase or slave stretch
	assign scl_o         = 1'b0;
	assign scl_oe_o      = (mst_reg == itcr_pkg::ITCR_MST_LOW) ||
	                       (slv_reg != itcr_pkg::ITCR_SLV_IDLE);
	assign mst_busy_o    = (mst_reg != itcr_pkg::ITCR_MST_IDLE);
	assign slv_release_o = rel_reg;

endmodule : itcr_timing

//--- tb/itcr_i2c_peer.sv
// Far side of the local I2C bus: pull-up wire, stretching slave, framed master clock
`timescale 1ns/1ps
module itcr_i2c_peer (
	input  wire logic dut_oe_i,
	input  wire logic hold_i,
	input  wire logic frame_i,
	output logic      scl_line_o
);
	logic mst_scl;
	// Far master clock toggles only within frames and rests high between them
	initial begin
		mst_scl = 1'b1;
		#1; // Keeps link edges off the block's clock edges
		forever begin
			#62.5;
			mst_scl = frame_i ? ~mst_scl : 1'b1;
		end
	end
	// Open drain: any party pulling wins, else the pull-up lifts the wire
	assign scl_line_o = mst_scl & ~dut_oe_i & ~hold_i;
endmodule : itcr_i2c_peer

//--- tb/itcr_timing_assertions.sv
// Port-level checker for the I2C timing block
`timescale 1ns/1ps
module itcr_timing_assertions (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_o,
	input wire logic       slv_data_ready_i,
	input wire logic       slv_release_o,
	input wire logic       scl_rx_o,
	input wire logic       sda_rx_o,
	input wire logic       mst_busy_o,
	input wire logic [1:0] clock_source_o,
	input wire logic [7:0] general_purpose_bits_field_o
);
	logic [7:0]  low_reg, low_next;
	logic [11:0] len_reg, len_next;
	int          lo;
	// Shadow of the low count, and how long SCL has been pulled so far
	always_comb begin
		low_next = (reg_wr_i && reg_addr_i == 8'h12) ? reg_wdata_i : low_reg;
		len_next = scl_oe_o ? len_reg + 12'h001 : 12'h000;
		if (srst_i) begin
			low_next = 8'h82;
			len_next = 12'h000;
		end
	end
	always_ff @(posedge clk_i) begin
		low_reg <= low_next;
		len_reg <= len_next;
	end
	// A zero count acts as one unit
	assign lo = (low_reg == 8'h00) ? 5 : 5 * int'(low_reg);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	AST_GP_WR: assert property (
		reg_wr_i && reg_addr_i == 8'h13 |=> general_purpose_bits_field_o == $past(reg_wdata_i))
		else $error("general purpose bits do not follow their register");
	AST_CS_WR: assert property (
		reg_wr_i && reg_addr_i == 8'h14 |=> clock_source_o == $past(reg_wdata_i[2:1]))
		else $error("clock source does not follow its register");
	AST_MST_LOW: assert property ($rose(mst_busy_o) |-> scl_oe_o)
		else $error("master did not open with a low phase");
	AST_LOW_LEN: assert property (
		$fell(scl_oe_o) && $past(mst_busy_o) |-> len_reg >= lo - 5 && len_reg <= lo + 1)
		else $error("master low phase length off");
	AST_HIGH_MIN: assert property (
		$fell(scl_oe_o) && mst_busy_o |-> !scl_oe_o [*4])
		else $error("master high phase too short");
	AST_REL: assert property (slv_release_o |-> !scl_oe_o && $past(scl_oe_o))
		else $error("release pulse not at end of stretch");
	AST_SETUP: assert property (
		slv_data_ready_i && low_reg > 8'h01 |=> !slv_release_o [*4])
		else $error("stretch released before setup time");
	AST_OPEN_DRAIN: assert property (!scl_o)
		else $error("SCL output value not low");
	AST_RX_IDLE: assert property ($fell(srst_i) |-> scl_rx_o && sda_rx_o)
		else $error("received lines not idle after reset");
endmodule : itcr_timing_assertions

bind itcr_timing itcr_timing_assertions u_chk (
	.clk_i, .srst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .scl_o, .scl_oe_o,
	.slv_data_ready_i, .slv_release_o, .scl_rx_o, .sda_rx_o, .mst_busy_o,
	.clock_source_o, .general_purpose_bits_field_o
);

//--- tb/test_itcr_timing.sv
// Self-checking bench for the I2C timing configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module test_itcr_timing;
	logic       clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, mst_run_i = 0, sda_i = 1;
	logic       slv_stretch_i = 0, slv_data_ready_i = 0, hold = 0, frame = 0, seen;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, gp_o, d;
	logic [1:0] cs_o;
	logic       scl_o, scl_oe_o, slv_release_o, scl_rx_o, sda_rx_o, mst_busy_o, scl_line;
	int         bad_count = 0, checks_done = 0, n;
	logic [7:0] rst_v [6] = '{8'h17, 8'h82, 8'h82, 8'h00, 8'h00, 8'h00};
	logic [7:0] wr_v [6] = '{8'hB5, 8'h5A, 8'h3C, 8'h96, 8'hFF, 8'h77};
	logic [7:0] rb_v [6] = '{8'hB5, 8'h5A, 8'h3C, 8'h96, 8'h1F, 8'h00};
	initial forever #5 clk_i = ~clk_i;
	itcr_timing dut (.clk_i, .srst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .scl_i(scl_line), .sda_i, .scl_o, .scl_oe_o, .mst_run_i, .slv_stretch_i,
		.slv_data_ready_i, .slv_release_o, .scl_rx_o, .sda_rx_o, .mst_busy_o,
		.clock_source_o(cs_o), .general_purpose_bits_field_o(gp_o));
	itcr_i2c_peer peer (.dut_oe_i(scl_oe_o), .hold_i(hold), .frame_i(frame), .scl_line_o(scl_line));
	task automatic tick(int k); repeat (k) @(negedge clk_i); endtask : tick
	task automatic wr(logic [7:0] a, logic [7:0] v);
		reg_addr_i = a; reg_wdata_i = v; reg_wr_i = 1; tick(1); reg_wr_i = 0; tick(1);
	endtask : wr
	// Strobe, then one extra cycle so the registered answer has surely landed
	task automatic rd(logic [7:0] a, output logic [7:0] v);
		reg_addr_i = a; reg_rd_i = 1; tick(1); reg_rd_i = 0; tick(1); v = reg_rdata_o;
	endtask : rd
	task automatic until_oe(logic v, output int c);
		c = 0; while (scl_oe_o !== v && c < 4000) begin tick(1); c++; end
	endtask : until_oe
	task automatic pulse(int w, output logic s);
		s = 0;
		for (int i = 0; i < 25; i++) begin sda_i = (i >= w); tick(1); if (sda_rx_o === 1'b0) s = 1; end
	endtask : pulse
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// Main sequence: registers, master timing, slave stretch, filter, hold
	initial begin
		tick(8); srst_i = 0;
		foreach (rst_v[i]) begin rd(8'h10 + 8'(i), d); `CHK("reset value", rst_v[i], d) end
		foreach (wr_v[i]) wr(8'h10 + 8'(i), wr_v[i]);
		foreach (rb_v[i]) begin rd(8'h10 + 8'(i), d); `CHK("readback", rb_v[i], d) end
		`CHK("gp bits", 8'h96, gp_o)
		for (int c = 0; c < 4; c++) begin wr(8'h14, 8'(c << 1)); tick(1); `CHK("clk src", 2'(c), cs_o) end
		wr(8'h10, 8'h10); wr(8'h12, 8'h03); wr(8'h11, 8'h02); mst_run_i = 1;
		until_oe(1, n); until_oe(0, n); `CHK("low phase", 1'b1, n >= 10 && n <= 17)
		hold = 1; tick(20); `CHK("no drive in stretch", 1'b0, scl_oe_o)
		hold = 0; until_oe(1, n); `CHK("high after stretch", 1'b1, n >= 5 && n <= 30)
		mst_run_i = 0; until_oe(0, n); tick(3); `CHK("master idle", 1'b0, mst_busy_o)
		wr(8'h12, 8'h04); frame = 1; slv_stretch_i = 1; until_oe(1, n); tick(4);
		slv_data_ready_i = 1; tick(1); slv_data_ready_i = 0; n = 0;
		while (slv_release_o !== 1'b1 && n < 400) begin tick(1); n++; end
		`CHK("setup time", 1'b1, n >= 14 && n <= 26)
		`CHK("stretch ends", 1'b0, scl_oe_o)
		slv_stretch_i = 0; frame = 0; tick(10); wr(8'h10, 8'h03);
		pulse(3, seen); `CHK("short glitch", 1'b0, seen)
		pulse(6, seen); `CHK("wide pulse", 1'b1, seen)
		wr(8'h10, 8'h40); hold = 1; tick(3); sda_i = 0; n = 0;
		while (sda_rx_o !== 1'b0 && n < 60) begin tick(1); n++; end
		`CHK("sda hold", 1'b1, n >= 12 && n < 60)
		`CHK("scl seen low", 1'b0, scl_rx_o)
		hold = 0; sda_i = 1; tick(10);
		// Mid-run reset must bring the registers back to their reset values
		srst_i = 1; tick(2); srst_i = 0; `CHK("gp after reset", 8'h00, gp_o)
		rd(8'h12, d); `CHK("low after reset", 8'h82, d)
		wrap_up();
	end
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#200_000;
		bad_count++;
		wrap_up();
	end
endmodule : test_itcr_timing
